// ### hdl/fwpm_pin_mux.sv
/*
 * Pin mux for the parallel interface: shared control/flag pins, dedicated control
 * outputs and the interface clock pin, configured over APB.
 * Assumes FIFO status and waveform outputs come from logic on i_core_clk, while the
 * FIFO select pins and the interface clock pin come from outside and are synchronised.
 */
// Summary of operation
// R1 - Each shared pin shows a waveform control output, a FIFO flag or a constant high, chosen by the mode field.
// R2 - In slave-FIFO mode flag A shows the programmable-level flag of the selected FIFO.
// R3 - In slave-FIFO mode flag B shows the full flag of the selected FIFO.
// R4 - In slave-FIFO mode flag C shows the empty flag of the selected FIFO.
// R5 - The outside party drives the two FIFO select pins to pick the reported FIFO.
// R6 - With the internal source bit set the pin is driven at 50 MHz, whatever the rate bits hold.
// R7 - The interface clock is inverted when the inversion bit is set, either source.
// R8 - The interface clock times slave-FIFO data, FIFO control and the waveform engine.
// R9 - Six waveform control outputs exist, 3 to 5 dedicated, all defaulting high.
// R10 - With an external source the pin is undriven, sampled, and released after reset.
`timescale 1ns/10ps
module fwpm_pin_mux
    import fwpm_pkg::*;
#(
    parameter int NUM_FIFOS = 4
) (
    // Clock and reset.
    input wire logic i_core_clk,
    input wire logic i_rst,
    // APB slave.
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Internal sources.
    input wire logic [5:0] i_waveform_ctrl,
    input wire fwpm_fifo_flags_t [NUM_FIFOS-1:0] i_fifo_flags,
    // FIFO select pins from outside.
    input wire logic [1:0] i_fifo_select,
    // Shared and dedicated pins.
    output logic o_fifo_status_a,
    output logic o_fifo_status_b,
    output logic o_fifo_status_c,
    output logic o_waveform_ctrl_out_3,
    output logic o_waveform_ctrl_out_4,
    output logic o_waveform_ctrl_out_5,
    // Interface clock pin, three signals; enable low while driving.
    input wire logic i_interface_clock,
    output logic o_interface_clock,
    output logic o_interface_clock_oe_n,
    // Effective interface clock level and its rising-edge pulse for internal users.
    output logic o_if_clk_level,
    output logic o_if_clk_rise
);

    ////////////////////////////////////////////////////////////////////////////
    logic [31:0] cfg_reg;
    logic [5:0] ctrl_reg;
    logic [1:0] sel_meta_reg, sel_sync_reg;
    logic clk_meta_reg, clk_sync_reg, clk_prev_reg;
    logic [5:0] ctrl_out_reg;
    logic fa_reg, fb_reg, fc_reg;
    logic [2:0] div_cnt_reg;
    logic gen_clk_reg;

    wire wr_en = i_psel && i_penable && i_pwrite;
    wire hit_cfg = (i_paddr == FWPM_OFS_CFG);
    wire hit_ctrl = (i_paddr == FWPM_OFS_CTRL);
    wire hit_stat = (i_paddr == FWPM_OFS_STAT);
    wire hit_any = hit_cfg || hit_ctrl || hit_stat;

    wire fwpm_mode_t mode = fwpm_mode_t'(cfg_reg[FWPM_CFG_MODE_LO +: 2]);
    wire cfg_inv = cfg_reg[FWPM_CFG_INV];
    wire [1:0] cfg_freq = cfg_reg[FWPM_CFG_FREQ_LO +: 2];
    wire cfg_intclk = cfg_reg[FWPM_CFG_INTCLK];

    ////////////////////////////////////////////////////////////////////////////
    // APB answers in the access cycle; unmapped addresses raise pslverr.
    assign o_pready = 1'b1;
    assign o_pslverr = i_psel && i_penable && !hit_any;
    assign o_prdata = hit_cfg ? cfg_reg :
                      hit_ctrl ? {26'h0, ctrl_reg} :
                      hit_stat ? {24'h0, o_if_clk_level, cfg_intclk, sel_sync_reg,
                                  1'b0, fc_reg, fb_reg, fa_reg} : 32'h0;

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            cfg_reg <= FWPM_CFG_RST;
            ctrl_reg <= FWPM_CTRL_RST;
        end else if (wr_en && hit_cfg) begin
            cfg_reg <= i_pwdata & FWPM_CFG_MASK;
        end else if (wr_en && hit_ctrl) begin
            ctrl_reg <= i_pwdata[5:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outside pins pass two flops before anything reads them.
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            sel_meta_reg <= 2'h0;
            sel_sync_reg <= 2'h0;
            clk_meta_reg <= 1'b0;
            clk_sync_reg <= 1'b0;
            clk_prev_reg <= 1'b0;
        end else begin
            // R5 select pins
            sel_meta_reg <= i_fifo_select;
            sel_sync_reg <= sel_meta_reg;
            clk_meta_reg <= i_interface_clock;
            clk_sync_reg <= clk_meta_reg;
            clk_prev_reg <= o_if_clk_level;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // R2 flag A programmable
    wire fwpm_fifo_flags_t sel_flags = i_fifo_flags[sel_sync_reg];
    // R9 waveform outputs gated
    wire [5:0] wave_next = i_waveform_ctrl | ~ctrl_reg;
    wire fifo_mode = (mode == FWPM_MODE_SLAVE_FIFO);
    wire wave_mode = (mode == FWPM_MODE_WAVEFORM);
    // R1 shared pin choice
    wire fa_next = fifo_mode ? sel_flags.prog : (wave_mode ? wave_next[0] : 1'b1);
    // R3 flag B full
    wire fb_next = fifo_mode ? sel_flags.full : (wave_mode ? wave_next[1] : 1'b1);
    // R4 flag C empty
    wire fc_next = fifo_mode ? sel_flags.empty : (wave_mode ? wave_next[2] : 1'b1);

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            ctrl_out_reg <= FWPM_CTRL_RST;
            fa_reg <= 1'b1;
            fb_reg <= 1'b1;
            fc_reg <= 1'b1;
        end else begin
            ctrl_out_reg <= wave_next;
            fa_reg <= fa_next;
            fb_reg <= fb_next;
            fc_reg <= fc_next;
        end
    end

    assign o_fifo_status_a = fa_reg;
    assign o_fifo_status_b = fb_reg;
    assign o_fifo_status_c = fc_reg;
    assign o_waveform_ctrl_out_3 = ctrl_out_reg[3];
    assign o_waveform_ctrl_out_4 = ctrl_out_reg[4];
    assign o_waveform_ctrl_out_5 = ctrl_out_reg[5];

    ////////////////////////////////////////////////////////////////////////////
    // Integer division of the 100 MHz core gives 50 MHz for both the 30 and the 48 MHz rate settings.
    // R6 internal clock divider
    wire [2:0] half_cnt = (cfg_freq == 2'h0) ? 3'(FWPM_HALF_SLOW) : 3'(FWPM_HALF_FAST);
    wire div_wrap = (div_cnt_reg >= half_cnt - 3'h1);

    always_ff @(posedge i_core_clk) begin
        if (i_rst || !cfg_intclk) begin
            div_cnt_reg <= 3'h0;
            gen_clk_reg <= 1'b0;
        end else if (div_wrap) begin
            div_cnt_reg <= 3'h0;
            gen_clk_reg <= ~gen_clk_reg;
        end else begin
            div_cnt_reg <= div_cnt_reg + 3'h1;
        end
    end

    // R7 optional inversion
    wire raw_clk = cfg_intclk ? gen_clk_reg : clk_sync_reg;
    assign o_if_clk_level = raw_clk ^ cfg_inv;
    assign o_interface_clock = gen_clk_reg ^ cfg_inv;
    // R10 released when external
    assign o_interface_clock_oe_n = !cfg_intclk;
    // R8 interface timing reference
    assign o_if_clk_rise = o_if_clk_level && !clk_prev_reg;

endmodule

// ### hdl/fwpm_pkg.sv
/*
 * Package for the FIFO/waveform pin mux: register map, field layout and pin carriers.
 * Assumes a 32-bit APB slave with word-aligned registers at a 100 MHz core clock.
 */
package fwpm_pkg;

    // Register byte offsets.
    localparam logic [7:0] FWPM_OFS_CFG = 8'h00;
    localparam logic [7:0] FWPM_OFS_CTRL = 8'h04;
    localparam logic [7:0] FWPM_OFS_STAT = 8'h08;

    // Configuration register field positions.
    localparam int FWPM_CFG_MODE_LO = 0;
    localparam int FWPM_CFG_INV = 4;
    localparam int FWPM_CFG_FREQ_LO = 5;
    localparam int FWPM_CFG_INTCLK = 7;
    localparam logic [31:0] FWPM_CFG_RST = 32'h0000_0000;
    localparam logic [31:0] FWPM_CFG_MASK = 32'h0000_00F3;

    // Waveform control outputs all come up high.
    localparam logic [5:0] FWPM_CTRL_RST = 6'h3F;

    // Interface clock rates and the half-period divider counts they need.
    localparam int FWPM_CORE_HZ = 100_000_000;
    localparam int FWPM_INTERFACE_CLOCK_SLOW_HZ = 30_000_000;
    localparam int FWPM_INTERFACE_CLOCK_FAST_HZ = 48_000_000;
    localparam int FWPM_HALF_SLOW = FWPM_CORE_HZ / (2 * FWPM_INTERFACE_CLOCK_SLOW_HZ);
    localparam int FWPM_HALF_FAST = FWPM_CORE_HZ / (2 * FWPM_INTERFACE_CLOCK_FAST_HZ);

    typedef enum logic [1:0] {
        FWPM_MODE_PORTS,
        FWPM_MODE_RSVD,
        FWPM_MODE_WAVEFORM,
        FWPM_MODE_SLAVE_FIFO
    } fwpm_mode_t;

    // Per-FIFO status carrier.
    typedef struct packed {
        logic prog;
        logic full;
        logic empty;
    } fwpm_fifo_flags_t;

endpackage

// ### sim/fwpm_far_side.sv
/* Far-side logic model: FIFO select pins and an external interface clock.
   Assumes the bench opens and closes clock frames through i_run. */
`timescale 1ns/10ps
module fwpm_far_side (
    input wire logic i_run,
    input wire logic [1:0] i_pick,
    output logic [1:0] o_fifo_select,
    output logic o_ext_clk
);
    assign o_fifo_select = i_pick;
    initial o_ext_clk = 1'b0;
    always #62.5 if (i_run) o_ext_clk = ~o_ext_clk;
endmodule

// ### sim/fwpm_pin_mux_monitor.sv
/* Checker for the pin mux ports.
   Assumes registers change only through completed APB writes. */
`timescale 1ns/10ps
module fwpm_pin_mux_monitor
    import fwpm_pkg::*;
#(parameter int NUM_FIFOS = 4) (
    input wire logic i_core_clk, i_rst, i_psel, i_penable, i_pwrite, o_pready,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [5:0] i_waveform_ctrl,
    input wire fwpm_fifo_flags_t [NUM_FIFOS-1:0] i_fifo_flags,
    input wire logic [1:0] i_fifo_select,
    input wire logic o_fifo_status_a, o_fifo_status_b, o_fifo_status_c,
    input wire logic o_waveform_ctrl_out_3, o_waveform_ctrl_out_4, o_waveform_ctrl_out_5,
    input wire logic i_interface_clock, o_interface_clock_oe_n, o_if_clk_level,
    input wire logic o_interface_clock, o_if_clk_rise
);
    logic [7:0] cfg_reg;
    logic [5:0] en_reg;
    fwpm_fifo_flags_t pick_reg;
    wire wr = i_psel && i_penable && i_pwrite && o_pready;
    wire [2:0] abc = {o_fifo_status_c, o_fifo_status_b, o_fifo_status_a};
    wire [2:0] hi = {o_waveform_ctrl_out_5, o_waveform_ctrl_out_4, o_waveform_ctrl_out_3};
    // Shadow copies, since the checker cannot see the register bodies.
    always_ff @(posedge i_core_clk) begin
        pick_reg <= i_fifo_flags[i_fifo_select];
        if (i_rst) begin
            cfg_reg <= 8'h00;
            en_reg <= FWPM_CTRL_RST;
        end else if (wr && i_paddr == FWPM_OFS_CFG) begin
            cfg_reg <= i_pwdata[7:0] & FWPM_CFG_MASK[7:0];
        end else if (wr && i_paddr == FWPM_OFS_CTRL) begin
            en_reg <= i_pwdata[5:0];
        end
    end
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    sequence steady;
        cfg_reg[1:0] == 2'h3 && $stable(i_fifo_select) && $past(i_fifo_select, 2) == i_fifo_select;
    endsequence
    AST_FLAG_A:
        assert property (steady |=> o_fifo_status_a == pick_reg.prog) else $error("flag A");
    AST_FLAG_B:
        assert property (steady |=> o_fifo_status_b == pick_reg.full) else $error("flag B");
    AST_FLAG_C:
        assert property (steady |=> o_fifo_status_c == pick_reg.empty) else $error("flag C");
    AST_WAVE:
        assert property (cfg_reg[1:0] == 2'h2 |=> abc == $past(i_waveform_ctrl[2:0] | ~en_reg[2:0]))
            else $error("shared ctrl");
    AST_IDLE:
        assert property (cfg_reg[1] == 1'b0 |=> abc == 3'h7) else $error("shared idle");
    AST_OE:
        assert property ($stable(cfg_reg) |-> o_interface_clock_oe_n == !cfg_reg[7]) else $error("oe");
    AST_INVERT:
        assert property ((!cfg_reg[7] && $stable(i_interface_clock) && $stable(cfg_reg))[*5]
            |-> o_if_clk_level == (i_interface_clock ^ cfg_reg[4])) else $error("level");
    AST_PIN_LEVEL:
        assert property (!o_interface_clock_oe_n |-> o_interface_clock == o_if_clk_level)
            else $error("pin level");
    AST_RISE:
        assert property (o_if_clk_rise == (o_if_clk_level && !$past(o_if_clk_level)))
            else $error("rise pulse");
    AST_RESET:
        assert property ($fell(i_rst) |-> o_interface_clock_oe_n && abc == 3'h7 && hi == 3'h7)
            else $error("reset");
endmodule
bind fwpm_pin_mux fwpm_pin_mux_monitor #(.NUM_FIFOS(NUM_FIFOS)) fwpm_pin_mux_monitor_inst (.*);

// ### sim/tb.sv
/* Self-checking bench for the pin mux with APB master and far-side model.
   Assumes a 100 MHz core clock and zero-wait APB answers. */
`timescale 1ns/10ps
module tb;
    import fwpm_pkg::*;
    logic i_core_clk = 1'b0, i_rst = 1'b1, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
    logic [7:0] i_paddr = 8'h00;
    logic [31:0] i_pwdata = 32'h0, o_prdata, rd;
    logic [5:0] i_waveform_ctrl = 6'h00;
    fwpm_fifo_flags_t [3:0] i_fifo_flags = 12'hC54;
    logic [1:0] i_fifo_select, pick = 2'h0;
    logic o_pready, o_pslverr, er, o_fifo_status_a, o_fifo_status_b, o_fifo_status_c, ext;
    logic o_waveform_ctrl_out_3, o_waveform_ctrl_out_4, o_waveform_ctrl_out_5, run = 1'b0;
    logic o_interface_clock, o_interface_clock_oe_n, o_if_clk_level, o_if_clk_rise;
    wire i_interface_clock = o_interface_clock_oe_n ? ext : o_interface_clock;
    wire [2:0] abc = {o_fifo_status_c, o_fifo_status_b, o_fifo_status_a};
    wire [2:0] hi = {o_waveform_ctrl_out_5, o_waveform_ctrl_out_4, o_waveform_ctrl_out_3};
    logic [7:0] cfg_t [8] = '{8'h03, 8'h03, 8'h03, 8'h03, 8'h02, 8'h02, 8'h00, 8'h01};
    logic [5:0] wc_t [8] = '{6'h15, 6'h2A, 6'h00, 6'h3F, 6'h02, 6'h05, 6'h00, 6'h3F};
    logic [2:0] ex_t [8] = '{3'h1, 3'h2, 3'h4, 3'h3, 3'h2, 3'h5, 3'h7, 3'h7};
    int err_count = 0, num_checks = 0, n;
    fwpm_pin_mux #(.NUM_FIFOS(4)) fwpm_pin_mux_inst (.*);
    fwpm_far_side fwpm_far_side_inst (.i_run(run), .i_pick(pick), .o_fifo_select(i_fifo_select),
        .o_ext_clk(ext));
    always #5 i_core_clk = ~i_core_clk;
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        num_checks++;
        if (s !== e) begin
            err_count++;
            $display("Error %s exp %h got %h", nm, e, s);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_core_clk) i_penable <= 1'b1;
        do @(posedge i_core_clk); while (o_pready !== 1'b1);
        rd = o_prdata;
        er = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        @(posedge i_core_clk);
    endtask
    task automatic count_rises(input int cyc);
        n = 0;
        repeat (cyc) @(posedge i_core_clk) n += o_if_clk_rise;
    endtask
    task automatic end_sim;
        if (err_count == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge i_core_clk);
        i_rst <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, FWPM_OFS_CFG, {24'h0, cfg_t[i]});
            pick <= i[1:0];
            i_waveform_ctrl <= wc_t[i];
            repeat (6) @(posedge i_core_clk);
            chk("shared", {29'h0, ex_t[i]}, {29'h0, abc});
            chk("dedicated", {29'h0, wc_t[i][5:3]}, {29'h0, hi});
        end
        i_waveform_ctrl <= 6'h00;
        apb(1'b1, FWPM_OFS_CTRL, 32'h0);
        repeat (3) @(posedge i_core_clk);
        chk("masked", 32'h7, {29'h0, hi});
        apb(1'b0, FWPM_OFS_CTRL, 32'h0);
        chk("ctrl_rd", 32'h0, rd);
        apb(1'b0, 8'h0C, 32'h0);
        chk("unmapped", 32'h1, {31'h0, er});
        chk("unmapped_rd", 32'h0, rd);
        apb(1'b1, FWPM_OFS_CFG, 32'h80);
        count_rises(20);
        chk("int_oe", 32'h0, {31'h0, o_interface_clock_oe_n});
        chk("int_rises", 32'h1, {31'h0, n > 4});
        apb(1'b1, FWPM_OFS_CFG, 32'h0);
        run <= 1'b1;
        count_rises(200);
        run <= 1'b0;
        chk("ext_rises", 32'h1, {31'h0, n > 12});
        chk("ext_oe", 32'h1, {31'h0, o_interface_clock_oe_n});
        apb(1'b1, FWPM_OFS_CFG, 32'h10);
        repeat (6) @(posedge i_core_clk);
        chk("ext_inv", {31'h0, ~ext}, {31'h0, o_if_clk_level});
        apb(1'b1, FWPM_OFS_CFG, 32'h80);
        i_rst <= 1'b1;
        repeat (3) @(posedge i_core_clk);
        i_rst <= 1'b0;
        @(posedge i_core_clk);
        chk("rst_pins", 32'hF, {28'h0, o_interface_clock_oe_n, abc});
        apb(1'b0, FWPM_OFS_CFG, 32'h0);
        chk("rst_cfg", 32'h0, rd);
        end_sim();
    end
    initial begin
        #100000;
        err_count++;
        end_sim();
    end
endmodule
